/* rtl/scpl_defs.vh */
`ifndef SCPL_DEFS_VH
`define SCPL_DEFS_VH
// ****************************************
// timing
// ****************************************
`define SCPL_CLK_HZ 20000000
`define SCPL_T_IN_MS 250
`define SCPL_WATCHDOG_TIMEOUT_MS 310
`define SCPL_T_IN_CYC 5000000
`define SCPL_WATCHDOG_TIMEOUT_CYC 6200000
`define SCPL_CNT_W 23
`define SCPL_CLKMON_CYC 2000
// ****************************************
// serial word layout
// ****************************************
`define SCPL_WORD_W 16
`define SCPL_BIT_WD 15
`define SCPL_ADDR_HI 12
`define SCPL_ADDR_LO 9
`define SCPL_DATA_HI 8
`define SCPL_CNT_LAST 4'h0
`define SCPL_CNT_FULL 4'hf
// ****************************************
// register addresses
// ****************************************
`define SCPL_A_STATUS 4'h0
`define SCPL_A_GCR 4'h1
`define SCPL_A_FAULT0 4'h2
`define SCPL_A_FAULT1 4'h3
`define SCPL_A_DIAG0 4'h4
`define SCPL_A_DIAG1 4'h5
`define SCPL_A_CTRL 4'h6
// gcr bits
`define SCPL_GCR_SEL_LO 0
`define SCPL_GCR_SEL_HI 1
`define SCPL_GCR_WATCHDOG_DISABLE 2
`define SCPL_GCR_TH 3
// ctrl bits
`define SCPL_CTRL_DIR_DIS 0
`define SCPL_CTRL_PWM0 1
`define SCPL_CTRL_PWM1 2
`define SCPL_RST_9 9'h000
`define SCPL_ZERO_16 16'h0000
`define SCPL_SYNC_RST 10'h0b0
`endif

/* rtl/scpl_top.v */
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] sense select routes ch0, ch1, temp, off
// [RULE2] track-and-hold keeps pre-turnoff current while off
// [RULE3] overcurrent window disables sense output
// [RULE4] no sensing in fail-safe or without logic supply
// [RULE5] sync pulled low when sense accurate
// [RULE6] sync rises at every channel turn-off
// [RULE7] direct input low off, high on
// [RULE8] direct input rising edge wakes from sleep
// [RULE9] load type low bulb, high motor
// [RULE10] fault flag low on any fault
// [RULE11] sticky fault bits cleared by read
// [RULE12] pwm clock monitored, failure flagged
// [RULE13] pwm module sets on-time and delay
// [RULE14] reset low holds written registers reset
// [RULE15] sleep after input low time under reset
// [RULE16] reset rise wakes, watchdog samples first bit
// [RULE17] unchanged watchdog bit within timeout: fail-safe
// [RULE18] transfers and output drive only with select low
// [RULE19] select rise latches word to register
// [RULE20] select fall loads readable register out
// [RULE21] controller lowers select only with clock low
// [RULE22] sixteen-bit words, daisy-chain capable
// [RULE23] direct-input low time 250 ms nominal
// [RULE24] watchdog 310 ms, only when not disabled
// [RULE25] sample on clock fall, shift on rise
// [RULE26] msb first, address in bits 12 to 9
// [RULE27] controller toggles watchdog bit every word
`include "scpl_defs.vh"
module scpl_top #(
  parameter T_IN_CYC = `SCPL_T_IN_CYC,
  parameter WATCHDOG_TIMEOUT_CYC = `SCPL_WATCHDOG_TIMEOUT_CYC,
  parameter CLKMON_CYC = `SCPL_CLKMON_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // device pins
  input wire active_low_reset_pin_n,
  input wire [1:0] direct_in,
  input wire [1:0] load_type_select,
  input wire pwm_clock_in,
  input wire logic_supply_ok,
  // serial port
  input wire chip_select_n,
  input wire sclk,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe,
  // analog front end hooks
  input wire [1:0] overcurrent_window,
  input wire [1:0] sense_settled,
  input wire [1:0] pwm_drive,
  input wire [7:0] fault_events,
  // outputs
  output reg [1:0] channel_on,
  output reg [1:0] motor_profile,
  output reg [1:0] current_sense_out,
  output reg current_sense_oe,
  output reg sense_hold,
  output reg sync_oe,
  output reg fault_flag_n_oe,
  output reg clock_fail,
  output reg sleep_mode,
  output reg fail_safe
);
  // fault_events: 0 oc,1 ot,2 short to supply,3 severe short,4 open_load_on_state,5 open_load_off_state,6 ov,7 uv
  // ****************************************
  // input synchronisers
  // ****************************************
  // third stage only feeds edge detectors; logic reads the second
  // reset to idle pin levels: select high, load type pulled up
  reg [9:0] s1;
  reg [9:0] s2;
  reg [9:0] s3;
  wire [9:0] raw = {sdi, sclk, chip_select_n, pwm_clock_in, load_type_select,
                    direct_in, active_low_reset_pin_n, logic_supply_ok};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= `SCPL_SYNC_RST;
      s2 <= `SCPL_SYNC_RST;
      s3 <= `SCPL_SYNC_RST;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  wire vdd_ok = s2[0];
  wire rpin = s2[1];
  wire [1:0] din = s2[3:2];
  wire [1:0] din_d = s3[3:2];
  wire [1:0] lts = s2[5:4];
  wire pclk = s2[6];
  wire pclk_d = s3[6];
  wire csn = s2[7];
  wire csn_d = s3[7];
  wire sck = s2[8];
  wire sck_d = s3[8];
  wire si = s2[9];
  wire rpin_rise = rpin & ~s3[1];
  // ****************************************
  // serial shift logic
  // ****************************************
  reg [15:0] shin;
  reg [15:0] shout;
  reg [3:0] bitcnt;
  reg [8:0] global_config_reg;
  reg [8:0] ctrl;
  reg [7:0] status_sticky;
  reg wd_last;
  reg wd_seen;
  reg wd_kick;
  // read data follows the address of the previous word
  reg [3:0] rd_addr;
  reg rd_pulse;
  // set by the first falling clock, so an empty frame latches nothing
  reg frame_any;
  wire active = ~csn;
  wire sck_fall = active & sck_d & ~sck;
  wire sck_rise = active & ~sck_d & sck;
  wire cs_fall = csn_d & ~csn;
  wire cs_rise = ~csn_d & csn;
  // address field of the word just shifted in
  wire [3:0] waddr = shin[`SCPL_ADDR_HI:`SCPL_ADDR_LO];
  // readback selection, seven readable registers
  function [15:0] scpl_rd;
    input [3:0] a;
    input [8:0] g;
    input [8:0] c;
    input [7:0] st;
    input [1:0] ch;
    input fs;
    input ck;
    begin
      case (a)
        `SCPL_A_STATUS: scpl_rd = {3'h0, a, fs, ck, st[4:0], ch};
        `SCPL_A_GCR: scpl_rd = {3'h0, a, g};
        `SCPL_A_FAULT0: scpl_rd = {3'h0, a, 5'h00, st[3:0]};
        `SCPL_A_FAULT1: scpl_rd = {3'h0, a, 5'h00, st[3:0]};
        `SCPL_A_DIAG0: scpl_rd = {3'h0, a, 6'h00, st[7:5]};
        `SCPL_A_DIAG1: scpl_rd = {3'h0, a, 6'h00, st[7:5]};
        `SCPL_A_CTRL: scpl_rd = {3'h0, a, c};
        default: scpl_rd = {3'h0, a, `SCPL_RST_9};
      endcase
    end
  endfunction
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shin <= `SCPL_ZERO_16;
      shout <= `SCPL_ZERO_16;
      bitcnt <= `SCPL_CNT_FULL;
      global_config_reg <= `SCPL_RST_9;
      ctrl <= `SCPL_RST_9;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      wd_last <= 1'b0;
      wd_seen <= 1'b0;
      wd_kick <= 1'b0;
      rd_addr <= `SCPL_A_STATUS;
      rd_pulse <= 1'b0;
      frame_any <= 1'b0;
    end else begin
      wd_kick <= 1'b0;
      rd_pulse <= 1'b0;
      sdo_oe <= active & vdd_ok; // [RULE18] [RULE4]
      if (cs_fall) begin
        shout <= scpl_rd(rd_addr, global_config_reg, ctrl, status_sticky, channel_on, fail_safe,
                         clock_fail); // [RULE20]
        // read clear pulses once per frame, at select fall
        rd_pulse <= 1'b1; // [RULE11]
        bitcnt <= `SCPL_CNT_FULL;
        frame_any <= 1'b0;
      end else if (sck_fall) begin
        shin <= {shin[14:0], si}; // [RULE25] [RULE26]
        // bitcnt wraps back to full after sixteen falls: a whole word
        bitcnt <= bitcnt - 4'h1;
        frame_any <= 1'b1;
        if (bitcnt == `SCPL_CNT_FULL) begin
          wd_kick <= (si != wd_last) | ~wd_seen; // [RULE16]
          wd_last <= si;
          wd_seen <= 1'b1;
        end
      end else if (sck_rise) begin
        sdo <= shout[15]; // [RULE25] [RULE22]
        // previous input shifts behind, giving the daisy chain path
        shout <= {shout[14:0], shin[15]};
      end
      if (!rpin) begin
        global_config_reg <= `SCPL_RST_9; // [RULE14]
        ctrl <= `SCPL_RST_9;
        wd_seen <= 1'b0;
      end else if (cs_rise && frame_any && bitcnt == `SCPL_CNT_FULL) begin
        // only complete words latch; an aborted frame is dropped
        rd_addr <= waddr; // [RULE19]
        if (waddr == `SCPL_A_GCR) global_config_reg <= shin[`SCPL_DATA_HI:0];
        if (waddr == `SCPL_A_CTRL) ctrl <= shin[`SCPL_DATA_HI:0];
      end
    end
  end
  // ****************************************
  // mode control: sleep, wake, watchdog
  // ****************************************
  reg [`SCPL_CNT_W-1:0] in_low_cnt;
  reg [`SCPL_CNT_W-1:0] wd_cnt;
  reg wd_run;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_mode <= 1'b1;
      fail_safe <= 1'b0;
      in_low_cnt <= {`SCPL_CNT_W{1'b0}};
      wd_cnt <= {`SCPL_CNT_W{1'b0}};
      wd_run <= 1'b0;
    end else begin
      // a wake event beats the sleep countdown in the same cycle
      if (|(din & ~din_d) || rpin_rise) begin
        sleep_mode <= 1'b0; // [RULE8] [RULE16]
      end else if (!rpin && din == 2'b00) begin
        if (in_low_cnt >= T_IN_CYC - 1) sleep_mode <= 1'b1; // [RULE15] [RULE23]
      end
      if (rpin || din != 2'b00) in_low_cnt <= {`SCPL_CNT_W{1'b0}};
      else if (!sleep_mode) in_low_cnt <= in_low_cnt + 1'b1;
      // fail-safe is left only through the reset pin
      if (!rpin) begin
        wd_run <= 1'b0;
        fail_safe <= 1'b0;
        wd_cnt <= {`SCPL_CNT_W{1'b0}};
      // a kick restarts the timeout even while it is disabled
      end else if (rpin_rise || wd_kick) begin
        wd_run <= 1'b1;
        wd_cnt <= {`SCPL_CNT_W{1'b0}};
      end else if (wd_run && !global_config_reg[`SCPL_GCR_WATCHDOG_DISABLE]) begin // [RULE24]
        if (wd_cnt >= WATCHDOG_TIMEOUT_CYC - 1) fail_safe <= 1'b1; // [RULE17]
        else wd_cnt <= wd_cnt + 1'b1;
      end
    end
  end
  // ****************************************
  // channels, clock monitor, faults
  // ****************************************
  reg [11:0] clk_cnt;
  reg [1:0] on_prev;
  // fail-safe drops pwm control and falls back to the direct inputs
  wire use_pwm0 = ctrl[`SCPL_CTRL_PWM0] & ~fail_safe;
  wire use_pwm1 = ctrl[`SCPL_CTRL_PWM1] & ~fail_safe;
  wire dir_ok = ~ctrl[`SCPL_CTRL_DIR_DIS] | fail_safe;
  wire [1:0] next_on;
  assign next_on[0] = ~sleep_mode & (use_pwm0 ? pwm_drive[0] : dir_ok & din[0]); // [RULE7] [RULE13]
  assign next_on[1] = ~sleep_mode & (use_pwm1 ? pwm_drive[1] : dir_ok & din[1]); // [RULE7] [RULE13]
  wire [7:0] next_sticky = status_sticky | fault_events;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_on <= 2'b00;
      on_prev <= 2'b00;
      motor_profile <= 2'b11;
      clk_cnt <= 12'h000;
      clock_fail <= 1'b0;
      status_sticky <= 8'h00;
      fault_flag_n_oe <= 1'b0;
    end else begin
      channel_on <= next_on;
      on_prev <= channel_on;
      motor_profile <= lts; // [RULE9]
      if (pclk != pclk_d) clk_cnt <= 12'h000;
      else if (clk_cnt < CLKMON_CYC) clk_cnt <= clk_cnt + 12'h001;
      // a stopped clock only matters while a channel runs from pwm
      // a new failure wins over the status read clear
      if (clk_cnt >= CLKMON_CYC && (use_pwm0 | use_pwm1)) clock_fail <= 1'b1; // [RULE12]
      else if (rd_pulse && rd_addr == `SCPL_A_STATUS) clock_fail <= 1'b0;
      // new events win over the read clear
      if (rd_pulse) status_sticky <= fault_events; // [RULE11]
      else status_sticky <= next_sticky;
      fault_flag_n_oe <= |next_sticky | clock_fail; // [RULE10]
    end
  end
  // ****************************************
  // current sense and sync
  // ****************************************
  wire sel_lo = global_config_reg[`SCPL_GCR_SEL_LO];
  wire sel_hi = global_config_reg[`SCPL_GCR_SEL_HI];
  wire th_en = global_config_reg[`SCPL_GCR_TH];
  wire [1:0] sel = {sel_hi, sel_lo};
  wire ch_idx = (sel == 2'b10);
  wire turn_off = |(on_prev & ~channel_on);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      current_sense_out <= 2'b00;
      current_sense_oe <= 1'b0;
      sense_hold <= 1'b0;
      sync_oe <= 1'b0;
    end else begin
      current_sense_out <= sel; // [RULE1]
      // analog mux code: 01 ch0, 10 ch1, 11 temperature
      current_sense_oe <= (sel != 2'b00) & ~(|overcurrent_window) & ~fail_safe
                          & vdd_ok; // [RULE1] [RULE3] [RULE4]
      // hold is blocked for the temperature code only; off code 00 still holds on channel 0 off
      sense_hold <= th_en & (sel != 2'b11) & ~channel_on[ch_idx]; // [RULE2]
      // release first, so a turn-off while sync is pulled low shows a rising sync edge
      if (turn_off) sync_oe <= 1'b0; // [RULE6]
      else sync_oe <= (sel != 2'b00) & channel_on[ch_idx] & sense_settled[ch_idx]; // [RULE5]
    end
  end
endmodule

/* testbench/scpl_chk.sv */
`timescale 1ns/1ns
// ********
// port checker
// ********
module scpl_chk (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // pins
  input wire active_low_reset_pin_n,
  input wire [1:0] direct_in,
  input wire logic_supply_ok,
  input wire chip_select_n,
  input wire [1:0] overcurrent_window,
  input wire [7:0] fault_events,
  // outputs
  input wire [1:0] channel_on,
  input wire [1:0] current_sense_out,
  input wire current_sense_oe,
  input wire sync_oe,
  input wire fault_flag_n_oe,
  input wire sleep_mode,
  input wire fail_safe,
  input wire sdo_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // select lines are synced, so allow their latency first
  sequence s_cs_idle;
    chip_select_n [*6];
  endsequence
  sequence s_wake;
    sleep_mode && $rose(direct_in[0]);
  endsequence
  a_oe_idle_select: assert property (s_cs_idle |-> !sdo_oe)
    else $error("serial out driven while deselected");
  a_sense_oc_off: assert property ((|overcurrent_window) [*4] |-> !current_sense_oe)
    else $error("sense driven in overcurrent window");
  a_sense_fs_off: assert property ((fail_safe || !logic_supply_ok) [*4] |-> !current_sense_oe)
    else $error("sense driven without service");
  a_fault_flag_low: assert property ((|fault_events) |-> ##[0:3] fault_flag_n_oe)
    else $error("fault flag not pulled low");
  a_sync_turn_off: assert property ($fell(channel_on[0]) |-> ##[0:3] !sync_oe)
    else $error("sync not released at turn off");
  a_wake_on_input: assert property (s_wake |-> ##[1:6] !sleep_mode)
    else $error("no wake on input rise");
  a_sel_code_on: assert property (current_sense_oe |-> current_sense_out != 2'b00)
    else $error("sense driven with no source");
  a_pin_reset_fs: assert property (!active_low_reset_pin_n [*5] |-> !fail_safe)
    else $error("fail safe kept in pin reset");
endmodule
bind scpl_top scpl_chk u_scpl_chk (.clk, .rst_b, .active_low_reset_pin_n, .direct_in,
  .logic_supply_ok, .chip_select_n, .overcurrent_window, .fault_events, .channel_on,
  .current_sense_out, .current_sense_oe, .sync_oe, .fault_flag_n_oe, .sleep_mode,
  .fail_safe, .sdo_oe);

/* testbench/scpl_mcu.sv */
`timescale 1ns/1ns
// ********
// controller model
// ********
module scpl_mcu (
  // clock
  input wire clk,
  // serial port
  output reg chip_select_n,
  output reg sclk,
  output reg sdi,
  input wire sdo
);
  reg wd_bit;
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    wd_bit = 1'b0;
  end
  // entered just after a falling clk edge; sclk period is 8 clk
  task automatic xfer(input [15:0] w, output [15:0] r);
    integer i;
    begin
      wd_bit = ~wd_bit;
      w[15] = wd_bit;
      chip_select_n = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 15; i >= 0; i = i - 1) begin
        sdi = w[i];
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        r[i] = sdo;
        sclk = 1'b0;
        repeat (4) @(negedge clk);
      end
      chip_select_n = 1'b1;
      // released line must not look like held data
      sdi = ~sdi;
      repeat (8) @(negedge clk);
    end
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ns
// ********
// bench
// ********
module testbench;
  localparam TIN = 200;
  localparam TWD = 300;
  localparam CKM = 50;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg active_low_reset_pin_n = 1'b0;
  reg [1:0] direct_in = 2'b00;
  reg [1:0] load_type_select = 2'b11;
  reg pwm_clock_in = 1'b0;
  reg pwm_run = 1'b1;
  reg logic_supply_ok = 1'b1;
  reg [1:0] overcurrent_window = 2'b00;
  reg [1:0] sense_settled = 2'b00;
  reg [1:0] pwm_drive = 2'b00;
  reg [7:0] fault_events = 8'h00;
  wire chip_select_n, sclk, sdi, sdo, sdo_oe, current_sense_oe, sense_hold, sync_oe;
  wire fault_flag_n_oe, clock_fail, sleep_mode, fail_safe;
  wire [1:0] channel_on, motor_profile, current_sense_out;
  integer n_errors = 0;
  integer n_checks = 0;
  integer k;
  reg [15:0] rd;
  always #25 clk = ~clk;
  always #250 if (pwm_run) pwm_clock_in = ~pwm_clock_in;
  scpl_top #(.T_IN_CYC(TIN), .WATCHDOG_TIMEOUT_CYC(TWD), .CLKMON_CYC(CKM)) u_scpl_top (.clk, .rst_b,
    .active_low_reset_pin_n, .direct_in, .load_type_select, .pwm_clock_in, .logic_supply_ok,
    .chip_select_n, .sclk, .sdi, .sdo, .sdo_oe, .overcurrent_window, .sense_settled,
    .pwm_drive, .fault_events, .channel_on, .motor_profile, .current_sense_out,
    .current_sense_oe, .sense_hold, .sync_oe, .fault_flag_n_oe, .clock_fail, .sleep_mode,
    .fail_safe);
  scpl_mcu u_scpl_mcu (.clk, .chip_select_n, .sclk, .sdi, .sdo);
  task chk(input [8*9:1] nm, input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task global_config_reg(input [8:0] d);
    u_scpl_mcu.xfer({3'h0, 4'h1, d}, rd);
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #(30000 * 50);
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    w(5);
    chk("sleep", {15'h0, sleep_mode}, 16'h0001);
    chk("profile", {14'h0, motor_profile}, 16'h0003);
    w(1);
    rst_b = 1'b1;
    w(20);
    chk("sleep", {15'h0, sleep_mode}, 16'h0001);
    direct_in = 2'b01;
    w(8);
    chk("sleep", {15'h0, sleep_mode}, 16'h0000);
    chk("chan", {14'h0, channel_on}, 16'h0001);
    load_type_select = 2'b01;
    w(8);
    chk("profile", {14'h0, motor_profile}, 16'h0001);
    direct_in = 2'b00;
    w(TIN / 2);
    chk("chan", {14'h0, channel_on}, 16'h0000);
    chk("sleep", {15'h0, sleep_mode}, 16'h0000);
    w(TIN / 2 + 20);
    chk("sleep", {15'h0, sleep_mode}, 16'h0001);
    $display("test direct done");
    active_low_reset_pin_n = 1'b1;
    w(10);
    chk("sleep", {15'h0, sleep_mode}, 16'h0000);
    for (k = 1; k < 4; k = k + 1) begin
      global_config_reg(k[8:0]);
      global_config_reg(k[8:0]);
      chk("readback", {7'h0, rd[8:0]}, k[15:0]);
      chk("sel", {14'h0, current_sense_out}, k[15:0]);
    end
    global_config_reg(9'h000);
    chk("sense_oe", {15'h0, current_sense_oe}, 16'h0000);
    global_config_reg(9'h001);
    overcurrent_window = 2'b01;
    w(8);
    chk("sense_oe", {15'h0, current_sense_oe}, 16'h0000);
    overcurrent_window = 2'b00;
    fault_events = 8'h01;
    w(1);
    fault_events = 8'h00;
    w(4);
    chk("fault", {15'h0, fault_flag_n_oe}, 16'h0001);
    global_config_reg(9'h009);
    direct_in = 2'b01;
    sense_settled = 2'b01;
    w(8);
    chk("sync", {15'h0, sync_oe}, 16'h0001);
    chk("hold", {15'h0, sense_hold}, 16'h0000);
    direct_in = 2'b00;
    w(8);
    chk("sync", {15'h0, sync_oe}, 16'h0000);
    chk("hold", {15'h0, sense_hold}, 16'h0001);
    sense_settled = 2'b00;
    $display("test serial done");
    u_scpl_mcu.xfer({3'h0, 4'h6, 9'h002}, rd);
    pwm_run = 1'b0;
    w(CKM + 20);
    chk("clk_fail", {15'h0, clock_fail}, 16'h0001);
    pwm_run = 1'b1;
    u_scpl_mcu.xfer({3'h0, 4'h0, 9'h000}, rd);
    u_scpl_mcu.xfer({3'h0, 4'h0, 9'h000}, rd);
    chk("status", {15'h0, rd[7]}, 16'h0001);
    chk("clk_fail", {15'h0, clock_fail}, 16'h0000);
    $display("test clock done");
    global_config_reg(9'h001);
    w(TWD / 3);
    chk("failsafe", {15'h0, fail_safe}, 16'h0000);
    w(TWD + 60);
    chk("failsafe", {15'h0, fail_safe}, 16'h0001);
    chk("sense_oe", {15'h0, current_sense_oe}, 16'h0000);
    active_low_reset_pin_n = 1'b0;
    w(10);
    chk("failsafe", {15'h0, fail_safe}, 16'h0000);
    active_low_reset_pin_n = 1'b1;
    w(10);
    global_config_reg(9'h004);
    w(TWD + 60);
    chk("failsafe", {15'h0, fail_safe}, 16'h0000);
    $display("test watchdog done");
    close_out;
  end
endmodule
